// ### can_ctrl_pkg.sv
// Package with register map, field positions and types of the control block
package can_ctrl_pkg;

    // Register addresses (byte offsets on the plain port)
    localparam logic [7:0] CONTROL_ADDR = 8'h00;
    localparam logic [7:0] COMMAND_ADDR = 8'h01;
    localparam logic [7:0] STATUS_ADDR = 8'h02;
    localparam logic [7:0] EVENT_ADDR = 8'h03;
    localparam logic [7:0] MASK_ADDR = 8'h04;
    localparam logic [7:0] FIFO_ADDR = 8'h05;
    localparam logic [7:0] WIN_BASE_ADDR = 8'h10;

    // Control register field positions
    localparam int RESET_REQ_POS = 0;
    localparam int RX_IRQ_EN_POS = 1;
    localparam int TX_IRQ_EN_POS = 2;
    localparam int ERR_IRQ_EN_POS = 3;
    localparam int OVR_IRQ_EN_POS = 4;

    // Values after reset
    localparam logic [7:0] CONTROL_RESET = 8'h01;
    localparam logic [7:0] COMMAND_READBACK = 8'hff;
    localparam logic [3:0] EVENT_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'hf;
    localparam logic [5:0] RAM_ZERO = 6'h00;

    // Event bit positions in the sticky event and mask registers
    localparam int EV_RX = 0;
    localparam int EV_TX = 1;
    localparam int EV_ERR = 2;
    localparam int EV_OVR = 3;
    localparam int EV_NUM = 4;

    // Receive RAM geometry and the receive window
    localparam int RAM_DEPTH = 64;
    localparam int WIN_LEN = 10;

    // Events presented by the protocol engine, one-cycle pulses
    typedef struct packed {
        logic rx_done;
        logic tx_done;
        logic tx_buf_free;
        logic err_change;
        logic overrun;
        logic bus_off;
    } core_event_t;

    // One byte written into the receive RAM by the protocol engine
    typedef struct packed {
        logic valid;
        logic is_echo;
        logic [3:0] index;
        logic [7:0] data;
    } rx_byte_t;

    // Controller operating state
    typedef enum logic [0:0] {
        MODE_OPERATING = 1'b0,
        MODE_RESET = 1'b1
    } ctrl_mode_t;

endpackage : can_ctrl_pkg

// ### can_irq_flags.sv
// Sticky event flags with masking and a level interrupt
`timescale 1ns/100ps
`default_nettype none
module can_irq_flags (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] set_pulse,
    input wire logic [3:0] clear_ones,
    input wire logic clear_all,
    input wire logic [3:0] mask_bits,
    output logic [3:0] flags,
    output logic irq
);
    logic [3:0] flags_reg;

    ////////////////////////////////////////////////////////////////////
    // One sticky bit per event; a set in the clear cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < can_ctrl_pkg::EV_NUM; gi++) begin : g_flag
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    flags_reg[gi] <= 1'b0;
                end else if (set_pulse[gi]) begin
                    flags_reg[gi] <= 1'b1;
                end else if (clear_ones[gi] || clear_all) begin
                    flags_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Level interrupt while any unmasked flag is set
    assign flags = flags_reg;
    assign irq = |(flags_reg & mask_bits);

    // An unmasked event on bit 0 raises the interrupt on the next cycle
    property p_irq_level;
        @(posedge core_clk) disable iff (rst)
        (set_pulse[0] && mask_bits[0]) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq did not follow an unmasked event");

    property p_flag_sticky;
        @(posedge core_clk) disable iff (rst)
        (flags[0] && !clear_ones[0] && !clear_all) |=> flags[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("event flag dropped without clear");
endmodule : can_irq_flags
`default_nettype wire

// ### can_rx_ptrs.sv
// Receive FIFO read and write pointers with start-address tracking
`timescale 1ns/100ps
`default_nettype none
module can_rx_ptrs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ptr_reset,
    input wire logic release_buf,
    input wire logic [5:0] msg_len,
    input wire logic wr_advance,
    output logic [5:0] rd_ptr,
    output logic [5:0] wr_ptr,
    output logic [5:0] start_addr
);
    logic [5:0] rd_ptr_reg;
    logic [5:0] wr_ptr_reg;
    logic [5:0] start_reg;

    ////////////////////////////////////////////////////////////////////
    // Start address moves with each release outside a pointer reset; hardware reset goes to zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            start_reg <= can_ctrl_pkg::RAM_ZERO;
        end else if (release_buf && !ptr_reset) begin
            start_reg <= rd_ptr_reg + msg_len;
        end
    end

    // Read pointer returns to the valid start address on soft reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_ptr_reg <= can_ctrl_pkg::RAM_ZERO;
        end else if (ptr_reset) begin
            rd_ptr_reg <= start_reg;
        end else if (release_buf) begin
            rd_ptr_reg <= rd_ptr_reg + msg_len;
        end
    end

    // Write pointer follows the same reset points
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= can_ctrl_pkg::RAM_ZERO;
        end else if (ptr_reset) begin
            wr_ptr_reg <= start_reg;
        end else if (wr_advance) begin
            wr_ptr_reg <= wr_ptr_reg + msg_len;
        end
    end

    assign rd_ptr = rd_ptr_reg;
    assign wr_ptr = wr_ptr_reg;
    assign start_addr = start_reg;

    property p_ptr_reset;
        @(posedge core_clk) disable iff (rst)
        ptr_reset |=> (rd_ptr == $past(start_reg) && wr_ptr == rd_ptr);
    endproperty
    a_ptr_reset: assert property (p_ptr_reset)
        else $error("pointers not returned to start address");
endmodule : can_rx_ptrs
`default_nettype wire

// ### can_ctrl_core.sv
// Control register, reset mode, interrupts and receive window of the CAN core
//
// Contract
// - Command register always reads all ones
// - Bus-off sets error flag when enabled
// - Entering reset returns receive FIFO pointers
// - Reset mode echoes sent frames, no interrupt
// - Hardware reset puts pointers at zero
// - Soft or bus-off reset uses start address
// - Overrun enable gates overrun interrupt
// - Error enable gates error/bus change interrupt
// - Transmit enable gates transmit interrupt
// - Control register is readable and writable
// - Reset request aborts frame, enters reset
// - Reset request forced by reset, bus-off
`timescale 1ns/100ps
`default_nettype none
module can_ctrl_core (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire can_ctrl_pkg::core_event_t core_event,
    input wire can_ctrl_pkg::rx_byte_t rx_byte,
    input wire logic [5:0] msg_len,
    input wire logic bus_off_status,
    output logic in_reset_mode,
    output logic abort_frame,
    output logic rx_lock,
    output logic irq
);
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [7:0] rdata_reg;
    logic [3:0] mask_reg;
    logic [7:0] rx_ram_reg [can_ctrl_pkg::RAM_DEPTH];
    logic rx_lock_reg;
    logic reset_req_d_reg;
    logic [3:0] flags;
    logic [3:0] ev_set;
    logic [3:0] ev_clear;
    logic [5:0] rd_ptr;
    logic [5:0] wr_ptr;
    logic [5:0] start_addr;
    logic reset_enter;
    logic release_buf;
    logic wr_advance;
    logic [5:0] ram_wr_addr;
    logic [5:0] ram_rd_addr;
    logic [3:0] win_idx;
    can_ctrl_pkg::ctrl_mode_t mode;

    ////////////////////////////////////////////////////////////////////
    // Control register next value: software write, reset request bit forced on bus-off
    always_comb begin
        control_next = control_reg;
        if (wr_en && addr == can_ctrl_pkg::CONTROL_ADDR) begin
            control_next = wdata & 8'h1f;
        end
        if (bus_off_status || core_event.bus_off) begin
            control_next[can_ctrl_pkg::RESET_REQ_POS] = 1'b1;
        end
    end

    // Control register; hardware reset sets the reset request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            control_reg <= can_ctrl_pkg::CONTROL_RESET;
        end else begin
            control_reg <= control_next;
        end
    end

    // Mode follows the reset request bit
    assign mode = control_reg[can_ctrl_pkg::RESET_REQ_POS] ?
        can_ctrl_pkg::MODE_RESET : can_ctrl_pkg::MODE_OPERATING;
    assign in_reset_mode = (mode == can_ctrl_pkg::MODE_RESET);

    ////////////////////////////////////////////////////////////////////
    // Edge of the reset request, used to abort and reset pointers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reset_req_d_reg <= 1'b1;
        end else begin
            reset_req_d_reg <= control_reg[can_ctrl_pkg::RESET_REQ_POS];
        end
    end
    assign reset_enter = control_reg[can_ctrl_pkg::RESET_REQ_POS] &&
        !reset_req_d_reg;
    assign abort_frame = reset_enter;

    ////////////////////////////////////////////////////////////////////
    // Release command on the command address, ignored in reset mode
    assign release_buf = wr_en && addr == can_ctrl_pkg::COMMAND_ADDR &&
        wdata[2] && !in_reset_mode;

    // Frames that complete advance the write pointer; echoes do not
    assign wr_advance = core_event.rx_done && !in_reset_mode;

    can_rx_ptrs u_ptrs (
        .core_clk(core_clk),
        .rst(rst),
        .ptr_reset(reset_enter),
        .release_buf(release_buf),
        .msg_len(msg_len),
        .wr_advance(wr_advance),
        .rd_ptr(rd_ptr),
        .wr_ptr(wr_ptr),
        .start_addr(start_addr)
    );

    ////////////////////////////////////////////////////////////////////
    // Receive RAM: received bytes at the write pointer, echoes at read
    assign ram_wr_addr = rx_byte.is_echo ?
        6'(rd_ptr + 6'(rx_byte.index)) :
        6'(wr_ptr + 6'(rx_byte.index));

    always_ff @(posedge core_clk) begin
        if (rx_byte.valid) begin
            rx_ram_reg[ram_wr_addr] <= rx_byte.data;
        end
    end

    // Receive window locks only on real receptions
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_lock_reg <= 1'b0;
        end else if (reset_enter || release_buf) begin
            rx_lock_reg <= 1'b0;
        end else if (core_event.rx_done && !in_reset_mode) begin
            rx_lock_reg <= 1'b1;
        end
    end
    assign rx_lock = rx_lock_reg;

    ////////////////////////////////////////////////////////////////////
    // Events gated by the enables; no receive event in reset mode
    always_comb begin
        ev_set = '0;
        ev_set[can_ctrl_pkg::EV_RX] = core_event.rx_done &&
            !in_reset_mode &&
            control_reg[can_ctrl_pkg::RX_IRQ_EN_POS];
        ev_set[can_ctrl_pkg::EV_TX] =
            (core_event.tx_done || core_event.tx_buf_free) &&
            control_reg[can_ctrl_pkg::TX_IRQ_EN_POS];
        ev_set[can_ctrl_pkg::EV_ERR] =
            (core_event.err_change || core_event.bus_off) &&
            control_reg[can_ctrl_pkg::ERR_IRQ_EN_POS];
        ev_set[can_ctrl_pkg::EV_OVR] = core_event.overrun &&
            control_reg[can_ctrl_pkg::OVR_IRQ_EN_POS];
    end

    // Write-one-to-clear on the event register
    assign ev_clear = (wr_en && addr == can_ctrl_pkg::EVENT_ADDR) ?
        wdata[3:0] : 4'h0;

    can_irq_flags u_irq (
        .core_clk(core_clk),
        .rst(rst),
        .set_pulse(ev_set),
        .clear_ones(ev_clear),
        .clear_all(1'b0),
        .mask_bits(mask_reg),
        .flags(flags),
        .irq(irq)
    );

    // Interrupt mask register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mask_reg <= can_ctrl_pkg::MASK_RESET;
        end else if (wr_en && addr == can_ctrl_pkg::MASK_ADDR) begin
            mask_reg <= wdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive window read address
    assign win_idx = 4'(addr - can_ctrl_pkg::WIN_BASE_ADDR);
    assign ram_rd_addr = 6'(rd_ptr + 6'(win_idx));

    // Read data, one cycle after the read strobe, zero otherwise
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (!rd_en) begin
            rdata_reg <= 8'h00;
        end else begin
            case (addr)
                can_ctrl_pkg::CONTROL_ADDR:
                    rdata_reg <= control_reg;
                can_ctrl_pkg::COMMAND_ADDR:
                    rdata_reg <= can_ctrl_pkg::COMMAND_READBACK;
                can_ctrl_pkg::STATUS_ADDR:
                    rdata_reg <= {5'h00, rx_lock_reg, bus_off_status,
                        in_reset_mode};
                can_ctrl_pkg::EVENT_ADDR: rdata_reg <= {4'h0, flags};
                can_ctrl_pkg::MASK_ADDR: rdata_reg <= {4'h0, mask_reg};
                can_ctrl_pkg::FIFO_ADDR: rdata_reg <= {2'h0, start_addr};
                default: begin
                    if (addr >= can_ctrl_pkg::WIN_BASE_ADDR &&
                        addr < 8'(can_ctrl_pkg::WIN_BASE_ADDR +
                        can_ctrl_pkg::WIN_LEN)) begin
                        rdata_reg <= rx_ram_reg[ram_rd_addr];
                    end else begin
                        rdata_reg <= 8'h00;
                    end
                end
            endcase
        end
    end
    assign rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_cmd_ones;
        @(posedge core_clk) disable iff (rst)
        (rd_en && addr == can_ctrl_pkg::COMMAND_ADDR) |=> rdata == 8'hff;
    endproperty
    a_cmd_ones: assert property (p_cmd_ones)
        else $error("command read not all ones");

    property p_busoff_err;
        @(posedge core_clk) disable iff (rst)
        (core_event.bus_off && control_reg[3]) |=> flags[2];
    endproperty
    a_busoff_err: assert property (p_busoff_err)
        else $error("bus-off did not set error flag");

    property p_enter_ptrs;
        @(posedge core_clk) disable iff (rst)
        reset_enter |=> ##1 (rd_ptr == wr_ptr);
    endproperty
    a_enter_ptrs: assert property (p_enter_ptrs)
        else $error("pointers not reset on entering reset");

    property p_echo_noirq;
        @(posedge core_clk) disable iff (rst)
        (in_reset_mode && !flags[0] && ev_clear == 4'h0) |=>
            (!flags[0] && !rx_lock);
    endproperty
    a_echo_noirq: assert property (p_echo_noirq)
        else $error("receive event or lock in reset mode");

    property p_hw_zero;
        @(posedge core_clk) $fell(rst) |-> (start_addr == 6'h00);
    endproperty
    a_hw_zero: assert property (p_hw_zero)
        else $error("start address not zero after hardware reset");

    property p_ovr_gate;
        @(posedge core_clk) disable iff (rst)
        (!flags[3] && ev_clear == 4'h0 && !control_reg[4]) |=> !flags[3];
    endproperty
    a_ovr_gate: assert property (p_ovr_gate)
        else $error("overrun flag set while disabled");

    property p_err_gate;
        @(posedge core_clk) disable iff (rst)
        (core_event.err_change && control_reg[3]) |=> flags[2];
    endproperty
    a_err_gate: assert property (p_err_gate)
        else $error("error change lost");

    property p_tx_gate;
        @(posedge core_clk) disable iff (rst)
        (core_event.tx_done && control_reg[2]) |=> flags[1];
    endproperty
    a_tx_gate: assert property (p_tx_gate)
        else $error("transmit event lost");

    property p_ctrl_rw;
        @(posedge core_clk) disable iff (rst)
        (wr_en && addr == 8'h00 && !bus_off_status && !core_event.bus_off
        ##1 rd_en && addr == 8'h00) |=> rdata == ($past(wdata, 2) & 8'h1f);
    endproperty
    a_ctrl_rw: assert property (p_ctrl_rw)
        else $error("control read-back mismatch");

    property p_busoff_rr;
        @(posedge core_clk) disable iff (rst)
        bus_off_status |=> in_reset_mode;
    endproperty
    a_busoff_rr: assert property (p_busoff_rr)
        else $error("reset request not forced by bus-off");

    property p_abort;
        @(posedge core_clk) disable iff (rst)
        $rose(in_reset_mode) |-> abort_frame;
    endproperty
    a_abort: assert property (p_abort)
        else $error("no abort on entering reset");

    c_enter_reset: cover property (@(posedge core_clk) disable iff (rst)
        reset_enter);
    c_leave_reset: cover property (@(posedge core_clk) disable iff (rst)
        $fell(in_reset_mode));
    c_irq: cover property (@(posedge core_clk) disable iff (rst)
        $rose(irq));
    c_echo: cover property (@(posedge core_clk) disable iff (rst)
        in_reset_mode && rx_byte.valid && rx_byte.is_echo);
endmodule : can_ctrl_core
`default_nettype wire

// ### can_host_model.sv
// Host microcontroller model that drives the plain register port
`timescale 1ns/100ps
`default_nettype none
module can_host_model (
    input wire logic core_clk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr_en,
    output logic rd_en,
    input wire logic [7:0] rdata
);

    ////////////////////////////////////////////////////////////////////////
    // Bus idle at time zero
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One-cycle write; address and data go to their inverse once released
    // Returns just after the taking edge so the write has landed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask : wr

    // One-cycle read; data taken in the cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask : rd

endmodule : can_host_model
`default_nettype wire

// ### testbench.sv
// Self-checking testbench of the CAN control block
`timescale 1ns/100ps
`default_nettype none
module testbench;

    logic core_clk;
    logic rst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [7:0] rdata;
    can_ctrl_pkg::core_event_t core_event;
    can_ctrl_pkg::rx_byte_t rx_byte;
    logic [5:0] msg_len;
    logic bus_off_status;
    logic in_reset_mode;
    logic abort_frame;
    logic rx_lock;
    logic irq;
    int num_errors = 0;
    int total_checks = 0;
    int abort_count = 0;
    logic [7:0] rv;

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and host
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    can_ctrl_core dut_u (
        .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .core_event(core_event), .rx_byte(rx_byte), .msg_len(msg_len),
        .bus_off_status(bus_off_status), .in_reset_mode(in_reset_mode),
        .abort_frame(abort_frame), .rx_lock(rx_lock), .irq(irq)
    );

    can_host_model host_u (
        .core_clk(core_clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata)
    );

    // Counts abort pulses seen at the clock edge
    always @(posedge core_clk) begin
        if (abort_frame === 1'b1) begin
            abort_count++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        host_u.rd(a, rv);
        check(rv, exp);
    endtask : rd_check

    // One-cycle event pulse, then time for the flag to land
    task automatic pulse(input can_ctrl_pkg::core_event_t e);
        @(posedge core_clk);
        core_event <= e;
        @(posedge core_clk);
        core_event <= '0;
        @(posedge core_clk);
        #1;
    endtask : pulse

    // One echoed byte of a sent frame
    task automatic echo(input logic [3:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        rx_byte <= {1'b1, 1'b1, idx, d};
        @(posedge core_clk);
        rx_byte <= '0;
    endtask : echo

    task automatic hw_reset();
        rst <= 1'b1;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
    endtask : hw_reset

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_values();
        rd_check(can_ctrl_pkg::CONTROL_ADDR, 8'h01);
        rd_check(can_ctrl_pkg::FIFO_ADDR, 8'h00);
        rd_check(can_ctrl_pkg::EVENT_ADDR, 8'h00);
        rd_check(can_ctrl_pkg::MASK_ADDR, 8'h0f);
        check({7'h00, in_reset_mode}, 8'h01);
        check({7'h00, irq}, 8'h00);
        $display("test reset_values done");
    endtask : t_reset_values

    task automatic t_command();
        logic [7:0] vals [3] = '{8'h00, 8'h5a, 8'hfb};
        rd_check(can_ctrl_pkg::COMMAND_ADDR, 8'hff);
        foreach (vals[i]) begin
            host_u.wr(can_ctrl_pkg::COMMAND_ADDR, vals[i]);
            rd_check(can_ctrl_pkg::COMMAND_ADDR, 8'hff);
        end
        $display("test command done");
    endtask : t_command

    task automatic t_control_rw();
        host_u.wr(can_ctrl_pkg::CONTROL_ADDR, 8'hff);
        rd_check(can_ctrl_pkg::CONTROL_ADDR, 8'h1f);
        host_u.wr(can_ctrl_pkg::CONTROL_ADDR, 8'h1c);
        rd_check(can_ctrl_pkg::CONTROL_ADDR, 8'h1c);
        check({7'h00, in_reset_mode}, 8'h00);
        rd_check(8'h0f, 8'h00);
        $display("test control_rw done");
    endtask : t_control_rw

    // Overrun, error change, transmit done and buffer free, each with its enable off, then on, then masked and cleared
    task automatic t_enables();
        logic [5:0] evs [4] = '{6'h02, 6'h04, 6'h10, 6'h08};
        logic [7:0] ctl [4] = '{8'h10, 8'h08, 8'h04, 8'h04};
        logic [7:0] flg [4] = '{8'h08, 8'h04, 8'h02, 8'h02};
        for (int i = 0; i < 4; i++) begin
            host_u.wr(can_ctrl_pkg::CONTROL_ADDR, 8'h00);
            pulse(evs[i]);
            check({7'h00, irq}, 8'h00);
            rd_check(can_ctrl_pkg::EVENT_ADDR, 8'h00);
            host_u.wr(can_ctrl_pkg::CONTROL_ADDR, ctl[i]);
            pulse(evs[i]);
            check({7'h00, irq}, 8'h01);
            rd_check(can_ctrl_pkg::EVENT_ADDR, flg[i]);
            host_u.wr(can_ctrl_pkg::MASK_ADDR, 8'h00);
            check({7'h00, irq}, 8'h00);
            host_u.wr(can_ctrl_pkg::MASK_ADDR, 8'h0f);
            check({7'h00, irq}, 8'h01);
            host_u.wr(can_ctrl_pkg::EVENT_ADDR, flg[i]);
            rd_check(can_ctrl_pkg::EVENT_ADDR, 8'h00);
            check({7'h00, irq}, 8'h00);
        end
        $display("test enables done");
    endtask : t_enables

    task automatic t_bus_off();
        int n;
        host_u.wr(can_ctrl_pkg::CONTROL_ADDR, 8'h08);
        n = abort_count;
        bus_off_status <= 1'b1;
        pulse(6'h01);
        rd_check(can_ctrl_pkg::CONTROL_ADDR, 8'h09);
        rd_check(can_ctrl_pkg::EVENT_ADDR, 8'h04);
        check({7'h00, irq}, 8'h01);
        host_u.wr(can_ctrl_pkg::CONTROL_ADDR, 8'h08);
        rd_check(can_ctrl_pkg::CONTROL_ADDR, 8'h09);
        check(8'(abort_count - n), 8'h01);
        bus_off_status <= 1'b0;
        host_u.wr(can_ctrl_pkg::EVENT_ADDR, 8'h04);
        host_u.wr(can_ctrl_pkg::CONTROL_ADDR, 8'h00);
        check({7'h00, in_reset_mode}, 8'h00);
        $display("test bus_off done");
    endtask : t_bus_off

    // Release moves the start, soft reset keeps it, echo lands unlocked
    task automatic t_echo_start();
        msg_len <= 6'h05;
        host_u.wr(can_ctrl_pkg::CONTROL_ADDR, 8'h02);
        host_u.wr(can_ctrl_pkg::COMMAND_ADDR, 8'h04);
        host_u.wr(can_ctrl_pkg::CONTROL_ADDR, 8'h03);
        rd_check(can_ctrl_pkg::FIFO_ADDR, 8'h05);
        echo(4'h2, 8'ha5);
        pulse(6'h20);
        rd_check(8'h12, 8'ha5);
        check({6'h00, rx_lock, irq}, 8'h00);
        rd_check(can_ctrl_pkg::EVENT_ADDR, 8'h00);
        rd_check(can_ctrl_pkg::STATUS_ADDR, 8'h01);
        echo(4'h2, 8'h3c);
        rd_check(8'h12, 8'h3c);
        hw_reset();
        rd_check(can_ctrl_pkg::FIFO_ADDR, 8'h00);
        rd_check(can_ctrl_pkg::CONTROL_ADDR, 8'h01);
        $display("test echo_start done");
    endtask : t_echo_start

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        core_event = '0;
        rx_byte = '0;
        msg_len = 6'h00;
        bus_off_status = 1'b0;
        hw_reset();
        t_reset_values();
        t_command();
        t_control_rw();
        t_enables();
        t_bus_off();
        t_echo_start();
        finish_test();
    end

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        finish_test();
    end

endmodule : testbench
`default_nettype wire
